// *** swexec_regs.svh ***
// How it works
// - Op bits 15-12, mode 11-9, field 8-0
// - Direct mode uses bits 10-0
// - Relative: field plus program counter, 15 bits
// - X indexed: field plus index, no delay
// - B indexed: field plus B, no delay
// - Indirect chain from low 512 words
// - One extra memory cycle per indirection
// - Opcodes 01-03 load A, B, X
// - Opcodes 05-07 store A, B, X
// - Opcode 04 increments memory, two memory cycles
// - Opcode 12 adds, overflow on signed range
// - Opcode 14 subtracts, overflow on range
// - Opcode 16 multiplies B by memory
// - Product high in A, low in B
// - Opcode 17 divides double-length A and B
// - Quotient to B, remainder A, overflow
// - Opcode 11 ORs memory into A
// - Opcode 13 XORs memory into A
// - Indirect flag is bit 15
// - Data are signed two's complement
`ifndef SWEXEC_REGS_SVH
`define SWEXEC_REGS_SVH
`define OP_MSB         15
`define OP_LSB         12
`define MODE_MSB       11
`define MODE_LSB       9
`define FIELD_MSB      8
`define DIRECT_MSB     10
`define IND_FLAG_BIT   15
`define SIGN_BIT       15
`define ADDR_MSB       14
`define MEM_CYCLE_NS   1800
`define CLK_PERIOD_NS  100
`define MEM_CYCLE_CLKS ((`MEM_CYCLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define MUL_CYCLES     10
`define DIV_MIN_CYCLES 10
`define DIV_MAX_CYCLES 14
`define OP_LDA_CODE    4'h1
`define OP_LDB_CODE    4'h2
`define OP_LDX_CODE    4'h3
`define OP_INC_CODE    4'h4
`define OP_STA_CODE    4'h5
`define OP_STB_CODE    4'h6
`define OP_STX_CODE    4'h7
`define OP_IOR_CODE    4'h9
`define OP_ADD_CODE    4'ha
`define OP_XOR_CODE    4'hb
`define OP_SUB_CODE    4'hc
`define OP_MUL_CODE    4'he
`define OP_DIV_CODE    4'hf
`define MODE_REL       3'h4
`define MODE_XIDX      3'h5
`define MODE_BIDX      3'h6
`define MODE_IND       3'h7
`endif

// *** swexec_pkg.sv ***
package swexec_pkg;
    typedef logic [15:0] word_t;
    typedef logic [14:0] addr_t;
    typedef struct packed {
        logic  req;
        logic  we;
        addr_t addr;
        word_t wdata;
    } mem_req_t;
    typedef struct packed {
        word_t a;
        word_t b;
        word_t x;
        word_t p;
    } regs_t;
endpackage

// *** cycle_timer.sv ***
`timescale 1ns/1ns
`include "swexec_regs.svh"
// Divides sys_clk into one-cycle memory-cycle pulses while running
module cycle_timer (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic run,
    output logic      tick
);
    logic [4:0] count;
    logic [4:0] next_count;
    logic       next_tick;

    always_comb begin
        next_count = count;
        next_tick  = 1'b0;
        if (!run) begin
            next_count = 5'h0;
        end else if (count == 5'(`MEM_CYCLE_CLKS - 1)) begin
            next_count = 5'h0;
            next_tick  = 1'b1;
        end else begin
            next_count = count + 5'h1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count <= 5'h0;
            tick  <= 1'b0;
        end else begin
            count <= next_count;
            tick  <= next_tick;
        end
    end
endmodule

// *** swexec.sv ***
`timescale 1ns/1ns
`include "swexec_regs.svh"
module swexec
    import swexec_pkg::*;
(
    input  wire logic              sys_clk,
    input  wire logic              arst_n,
    input  wire logic              start,
    input  swexec_pkg::word_t      instr,
    input  swexec_pkg::regs_t      regs_in,
    input  wire logic              overflow_in,
    input  swexec_pkg::word_t      mem_rdata,
    output swexec_pkg::mem_req_t   mem,
    output swexec_pkg::regs_t      regs_out,
    output logic                   overflow_flag,
    output logic                   busy,
    output logic                   done,
    output logic                   illegal
);
    import swexec_pkg::*;

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic rs1;
    logic rst_n;
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rs1   <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rs1   <= 1'b1;
            rst_n <= rs1;
        end
    end

    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------
    function automatic addr_t add15(input word_t base, input word_t fld);
        word_t s;
        s = base + fld;
        return s[`ADDR_MSB:0];
    endfunction

    function automatic logic sgn_ovf(input word_t x, input word_t y,
                                     input word_t r);
        return (x[`SIGN_BIT] == y[`SIGN_BIT]) &&
               (r[`SIGN_BIT] != x[`SIGN_BIT]);
    endfunction

    typedef enum {S_IDLE, S_FETCH_IND, S_OPER, S_WRITE, S_LONG,
                  S_DONE} state_t;
    state_t state;
    state_t next_state;

    logic  tick;
    logic  run;
    assign run = (state != S_IDLE) && (state != S_DONE);
    // Memory cycles are counted by the timer, so slow ops stay honest
    cycle_timer u_timer (
        .clk   (sys_clk),
        .rst_n (rst_n),
        .run   (run),
        .tick  (tick)
    );

    word_t    ir;
    word_t    next_ir;
    addr_t    ea;
    addr_t    next_ea;
    regs_t    next_regs;
    logic     next_ovf;
    mem_req_t next_mem;
    logic [4:0] cnt;
    logic [4:0] next_cnt;
    logic [4:0] target;
    logic [4:0] next_target;
    logic     next_done;
    logic     next_ill;
    logic [31:0] prod;
    word_t    quo;
    word_t    rem;
    word_t    sum;
    word_t    dif;
    logic [3:0] opc;
    logic [2:0] mode;

    assign opc  = ir[`OP_MSB:`OP_LSB];
    assign mode = ir[`MODE_MSB:`MODE_LSB];
    // Signed arithmetic on two's-complement words
    // Sixteen-bit words only; no wide-word option
    assign prod = 32'($signed(regs_out.b) * $signed(mem_rdata));
    assign sum  = regs_out.a + mem_rdata;
    assign dif  = regs_out.a - mem_rdata;
    always_comb begin
        quo = 16'h0;
        rem = 16'h0;
        if (mem_rdata != 16'h0) begin
            quo = 16'($signed({regs_out.a, regs_out.b[14:0]}) /
                      $signed(mem_rdata));
            rem = 16'($signed({regs_out.a, regs_out.b[14:0]}) %
                      $signed(mem_rdata));
        end
    end

    function automatic logic div_ovf(input word_t d);
        return (d == 16'h0) || (regs_out.a[14:0] >= d[14:0]);
    endfunction

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_comb begin
        next_state  = state;
        next_ir     = ir;
        next_ea     = ea;
        next_regs   = regs_out;
        next_ovf    = overflow_flag;
        next_mem    = mem;
        next_cnt    = cnt;
        next_target = target;
        next_done   = 1'b0;
        next_ill    = illegal;
        unique case (state)
            S_IDLE: begin
                next_mem.req = 1'b0;
                if (start) begin
                    next_ir   = instr;
                    next_regs = regs_in;
                    next_ovf  = overflow_in;
                    next_ill  = 1'b0;
                    next_cnt  = 5'h0;
                    if (!instr[`MODE_MSB]) begin
                        next_ea = {4'h0, instr[`DIRECT_MSB:0]};
                        next_state = S_OPER;
                    end else begin
                        unique case (instr[`MODE_MSB:`MODE_LSB])
                            `MODE_REL:  next_ea = add15(regs_in.p,
                                {7'h0, instr[`FIELD_MSB:0]});
                            `MODE_XIDX: next_ea = add15(regs_in.x,
                                {7'h0, instr[`FIELD_MSB:0]});
                            `MODE_BIDX: next_ea = add15(regs_in.b,
                                {7'h0, instr[`FIELD_MSB:0]});
                            default:    next_ea = {6'h0,
                                instr[`FIELD_MSB:0]};
                        endcase
                        // Index modes add no cycle
                        next_state = (instr[`MODE_MSB:`MODE_LSB] ==
                                      `MODE_IND) ? S_FETCH_IND : S_OPER;
                    end
                    next_mem.req  = 1'b1;
                    next_mem.we   = 1'b0;
                    next_mem.addr = next_ea;
                end
            end
            S_FETCH_IND: begin
                // Each link costs one full memory cycle
                if (tick) begin
                    next_ea       = mem_rdata[`ADDR_MSB:0];
                    next_mem.addr = mem_rdata[`ADDR_MSB:0];
                    if (!mem_rdata[`IND_FLAG_BIT])
                        next_state = S_OPER;
                end
            end
            S_OPER: begin
                if (tick) begin
                    next_state = S_DONE;
                    unique case (opc)
                        `OP_LDA_CODE: next_regs.a = mem_rdata;
                        `OP_LDB_CODE: next_regs.b = mem_rdata;
                        `OP_LDX_CODE: next_regs.x = mem_rdata;
                        `OP_STA_CODE, `OP_STB_CODE, `OP_STX_CODE: begin
                            next_mem.we    = 1'b1;
                            next_mem.wdata = (opc == `OP_STA_CODE) ?
                                regs_out.a : (opc == `OP_STB_CODE) ?
                                regs_out.b : regs_out.x;
                            next_state = S_WRITE;
                        end
                        `OP_INC_CODE: begin
                            next_mem.we    = 1'b1;
                            next_mem.wdata = mem_rdata + 16'h1;
                            next_ovf = overflow_flag |
                                       (mem_rdata + 16'h1) >= 16'h8000;
                            next_cnt    = 5'h0;
                            next_target = 5'h1;
                            next_state  = S_LONG;
                        end
                        `OP_ADD_CODE: begin
                            next_regs.a = sum;
                            next_ovf = overflow_flag |
                                       sgn_ovf(regs_out.a, mem_rdata, sum);
                        end
                        `OP_SUB_CODE: begin
                            next_regs.a = dif;
                            next_ovf = overflow_flag |
                                       sgn_ovf(regs_out.a, ~mem_rdata, dif);
                        end
                        `OP_IOR_CODE: next_regs.a = regs_out.a |
                                                    mem_rdata;
                        `OP_XOR_CODE: next_regs.a = regs_out.a ^
                                                    mem_rdata;
                        `OP_MUL_CODE: begin
                            // Product split, low sign cleared
                            next_regs.a = prod[30:15];
                            next_regs.b = {1'b0, prod[14:0]};
                            next_cnt    = 5'h0;
                            next_target = 5'(`MUL_CYCLES - 2);
                            next_state  = S_LONG;
                        end
                        `OP_DIV_CODE: begin
                            next_cnt    = 5'h0;
                            next_target = 5'(`DIV_MIN_CYCLES - 2) +
                                5'(mem_rdata[1:0]);
                            if (div_ovf(mem_rdata)) begin
                                next_ovf = 1'b1;
                            end else begin
                                next_regs.b = quo;
                                next_regs.a = rem;
                            end
                            next_state = S_LONG;
                        end
                        default: next_ill = 1'b1;
                    endcase
                end
            end
            S_WRITE: begin
                next_mem.req = 1'b0;
                next_mem.we  = 1'b0;
                next_state   = S_DONE;
            end
            S_LONG: begin
                next_mem.req = 1'b0;
                next_mem.we  = 1'b0;
                if (tick) begin
                    next_cnt = cnt + 5'h1;
                    if (cnt + 5'h1 >= target)
                        next_state = S_DONE;
                end
            end
            S_DONE: begin
                next_mem.req = 1'b0;
                next_mem.we  = 1'b0;
                next_done    = 1'b1;
                next_state   = S_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state         <= S_IDLE;
            ir            <= 16'h0;
            ea            <= 15'h0;
            regs_out      <= '0;
            overflow_flag <= 1'b0;
            mem           <= '0;
            cnt           <= 5'h0;
            target        <= 5'h0;
            done          <= 1'b0;
            illegal       <= 1'b0;
            busy          <= 1'b0;
        end else begin
            state         <= next_state;
            ir            <= next_ir;
            ea            <= next_ea;
            regs_out      <= next_regs;
            overflow_flag <= next_ovf;
            mem           <= next_mem;
            cnt           <= next_cnt;
            target        <= next_target;
            done          <= next_done;
            illegal       <= next_ill;
            busy          <= (next_state != S_IDLE);
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    a_direct_addr: assert property (
        (state == S_IDLE && start && !instr[`MODE_MSB]) |=>
        mem.addr == {4'h0, $past(instr[`DIRECT_MSB:0])})
        else $error("direct address wrong");
    a_rel_addr: assert property (
        (state == S_IDLE && start && instr[11:9] == `MODE_REL) |=>
        mem.addr == add15($past(regs_in.p), {7'h0, $past(instr[8:0])}))
        else $error("relative address wrong");
    a_idx_nowait: assert property (
        (state == S_IDLE && start && instr[11:10] == 2'b11 && !instr[9])
        |=> state == S_OPER)
        else $error("indexed mode delayed");
    a_ind_start: assert property (
        (state == S_IDLE && start && instr[11:9] == `MODE_IND) |=>
        state == S_FETCH_IND && mem.addr[14:9] == 6'h0)
        else $error("indirect start wrong");
    a_ind_chain: assert property (
        (state == S_FETCH_IND && tick && mem_rdata[15]) |=>
        state == S_FETCH_IND)
        else $error("indirect chain ended early");
    a_load_a: assert property (
        (state == S_OPER && tick && opc == `OP_LDA_CODE) |=>
        regs_out.a == $past(mem_rdata))
        else $error("load A wrong");
    a_store_we: assert property (
        (state == S_OPER && tick && opc == `OP_STA_CODE) |=>
        mem.we && mem.wdata == $past(regs_out.a))
        else $error("store A wrong");
    a_add_sum: assert property (
        (state == S_OPER && tick && opc == `OP_ADD_CODE) |=>
        regs_out.a == $past(sum))
        else $error("add wrong");
    a_xor_res: assert property (
        (state == S_OPER && tick && opc == `OP_XOR_CODE) |=>
        regs_out.a == ($past(regs_out.a) ^ $past(mem_rdata)))
        else $error("xor wrong");
    a_mul_bsign: assert property (
        (state == S_OPER && tick && opc == `OP_MUL_CODE) |=>
        !regs_out.b[15])
        else $error("product low sign set");
    c_indirect: cover property (
        state == S_FETCH_IND ##1 state == S_OPER);
    c_mul: cover property (
        state == S_LONG ##1 state == S_DONE);
    c_store: cover property (state == S_WRITE);
endmodule

// *** mem_model.sv ***
`timescale 1ns/1ns
// ----------------------------------------
// Main memory model
// ----------------------------------------
module mem_model
    import swexec_pkg::*;
(
    input  wire logic               clk,
    input  wire logic [4:0]         lat,
    input  swexec_pkg::mem_req_t    mem,
    output swexec_pkg::word_t       rdata
);
    word_t      store [0:32767];
    word_t      last      = 16'h0000;
    addr_t      last_addr = 15'h0000;
    logic [4:0] wait_cnt  = 5'h00;
    logic       ready;

    // Read data shows only after lat clocks of a steady read; before
    // that, and while idle, the bus churns so early sampling is caught
    assign ready = mem.req && !mem.we && (wait_cnt >= lat)
                   && (last_addr == mem.addr);
    always_comb begin
        if (ready) begin
            rdata = store[mem.addr];
        end else begin
            rdata = ~last;
        end
    end

    // Plain always: the bench preloads words straight into the array
    always @(posedge clk) begin
        last      <= rdata;
        last_addr <= mem.addr;
        if (!mem.req || last_addr != mem.addr) begin
            wait_cnt <= 5'h00;
        end else if (wait_cnt != 5'h1f) begin
            wait_cnt <= wait_cnt + 5'h01;
        end
        if (mem.req && mem.we) begin
            store[mem.addr] <= mem.wdata;
        end
    end
endmodule

// *** test_single_word_operand_exec.sv ***
`timescale 1ns/1ns
module test_single_word_operand_exec;
    import swexec_pkg::*;
    typedef struct packed {
        word_t instr, ai, bi, xi;
        logic  ofi;
        addr_t ea;
        word_t mi, ae, be, xe;
        logic  ofe;
        word_t me;
    } row_t;

    logic       sys_clk;
    logic       arst_n;
    logic       start;
    word_t      instr;
    regs_t      regs_in;
    logic       overflow_in;
    word_t      mem_rdata;
    mem_req_t   mem;
    regs_t      regs_out;
    logic       overflow_flag;
    logic       busy;
    logic       done;
    logic       illegal;
    logic [4:0] lat;
    row_t       rows[$];
    int         tcyc [0:31];
    int         errors;
    int         cmp_count;
    int         n;

    swexec dut_u (
        .sys_clk(sys_clk), .arst_n(arst_n), .start(start), .instr(instr),
        .regs_in(regs_in), .overflow_in(overflow_in),
        .mem_rdata(mem_rdata), .mem(mem), .regs_out(regs_out),
        .overflow_flag(overflow_flag), .busy(busy), .done(done),
        .illegal(illegal)
    );
    mem_model mem_u (
        .clk(sys_clk), .lat(lat), .mem(mem), .rdata(mem_rdata)
    );

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic check(input word_t seen, input word_t exp,
                         input string what);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: %s seen %h expected %h",
                     $time, what, seen, exp);
        end
    endtask

    task automatic tally_and_finish;
        $display("comparisons %0d errors %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic add(word_t i, a, b, x, logic o, addr_t e, word_t m,
                       word_t ae, be, xe, logic oe, word_t me);
        rows.push_back(row_t'{i, a, b, x, o, e, m, ae, be, xe, oe, me});
    endtask

    // A second start at cycle 5 must be ignored while busy
    task automatic run(input word_t ins, input regs_t r, input logic o,
                       input word_t ins2, output int cnt);
        @(negedge sys_clk);
        instr       = ins;
        regs_in     = r;
        overflow_in = o;
        start       = 1'b1;
        @(negedge sys_clk);
        start = 1'b0;
        cnt   = 1;
        while (done !== 1'b1 && illegal !== 1'b1 && cnt < 400) begin
            @(negedge sys_clk);
            cnt++;
            if (cnt == 5 && ins2 != 16'h0000) begin
                instr = ins2;
                start = 1'b1;
            end else begin
                start = 1'b0;
            end
        end
        if (cnt >= 400) begin
            errors++;
            $display("mismatch at %0t: no completion", $time);
        end
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    initial begin
        repeat (30000) @(posedge sys_clk);
        errors++;
        tally_and_finish();
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        arst_n = 1'b0; start = 1'b0; instr = 16'h0000; lat = 5'h01;
        regs_in = '0; overflow_in = 1'b0; errors = 0; cmp_count = 0;
        repeat (20) @(negedge sys_clk);
        arst_n = 1'b1;
        repeat (4) @(negedge sys_clk);
        check({12'h000, busy, done, overflow_flag, mem.req}, 16'h0000, "rst");
        check(regs_out.a, 16'h0000, "rst a");
        add(16'h17ff, 16'h0000, 16'h1111, 16'h2222, 1'b0, 15'h07ff,
            16'h1234, 16'h1234, 16'h1111, 16'h2222, 1'b0, 16'h1234);
        add(16'h29ff, 16'h0000, 16'h1111, 16'h2222, 1'b0, 15'h01ef,
            16'hbeef, 16'h0000, 16'hbeef, 16'h2222, 1'b0, 16'hbeef);
        add(16'h3b00, 16'h0000, 16'h1111, 16'h7f00, 1'b0, 15'h0000,
            16'h0042, 16'h0000, 16'h1111, 16'h0042, 1'b0, 16'h0042);
        add(16'h5030, 16'h5a5a, 16'h1111, 16'h2222, 1'b0, 15'h0030,
            16'h0000, 16'h5a5a, 16'h1111, 16'h2222, 1'b0, 16'h5a5a);
        add(16'h6c05, 16'h5a5a, 16'h0010, 16'h2222, 1'b0, 15'h0015,
            16'hffff, 16'h5a5a, 16'h0010, 16'h2222, 1'b0, 16'h0010);
        add(16'h7031, 16'h5a5a, 16'h1111, 16'h2222, 1'b0, 15'h0031,
            16'h0000, 16'h5a5a, 16'h1111, 16'h2222, 1'b0, 16'h2222);
        add(16'h4032, 16'h0000, 16'h1111, 16'h2222, 1'b0, 15'h0032,
            16'h7fff, 16'h0000, 16'h1111, 16'h2222, 1'b1, 16'h8000);
        add(16'h4033, 16'h0000, 16'h1111, 16'h2222, 1'b0, 15'h0033,
            16'hffff, 16'h0000, 16'h1111, 16'h2222, 1'b0, 16'h0000);
        add(16'ha034, 16'h0001, 16'h1111, 16'h2222, 1'b0, 15'h0034,
            16'h7fff, 16'h8000, 16'h1111, 16'h2222, 1'b1, 16'h7fff);
        add(16'ha035, 16'hffff, 16'h1111, 16'h2222, 1'b0, 15'h0035,
            16'h0001, 16'h0000, 16'h1111, 16'h2222, 1'b0, 16'h0001);
        add(16'hc036, 16'h8000, 16'h1111, 16'h2222, 1'b0, 15'h0036,
            16'h0001, 16'h7fff, 16'h1111, 16'h2222, 1'b1, 16'h0001);
        add(16'h9037, 16'h0f0f, 16'h1111, 16'h2222, 1'b1, 15'h0037,
            16'h3030, 16'h3f3f, 16'h1111, 16'h2222, 1'b1, 16'h3030);
        add(16'hb038, 16'hff00, 16'h1111, 16'h2222, 1'b0, 15'h0038,
            16'h0ff0, 16'hf0f0, 16'h1111, 16'h2222, 1'b0, 16'h0ff0);
        add(16'he039, 16'h0000, 16'hffff, 16'h2222, 1'b0, 15'h0039,
            16'h0002, 16'hffff, 16'h7ffe, 16'h2222, 1'b0, 16'h0002);
        add(16'he03a, 16'h0000, 16'h0003, 16'h2222, 1'b0, 15'h003a,
            16'h0005, 16'h0000, 16'h000f, 16'h2222, 1'b0, 16'h0005);
        add(16'hf03b, 16'h0000, 16'h0064, 16'h2222, 1'b0, 15'h003b,
            16'h0007, 16'h0002, 16'h000e, 16'h2222, 1'b0, 16'h0007);
        add(16'hf03c, 16'h0007, 16'h0000, 16'h2222, 1'b0, 15'h003c,
            16'h0007, 16'h0007, 16'h0000, 16'h2222, 1'b1, 16'h0007);
        foreach (rows[i]) begin
            mem_u.store[rows[i].ea] = rows[i].mi;
            run(rows[i].instr, '{rows[i].ai, rows[i].bi, rows[i].xi,
                16'h7ff0}, rows[i].ofi, 16'h0000, tcyc[i]);
            check(regs_out.a, rows[i].ae, "a");
            check(regs_out.b, rows[i].be, "b");
            check(regs_out.x, rows[i].xe, "x");
            check({15'h0000, overflow_flag}, {15'h0000, rows[i].ofe}, "of");
            check(mem_u.store[rows[i].ea], rows[i].me, "mem");
        end
        // Indexing costs no time; increment and multiply cost ticks
        check(16'(tcyc[2] - tcyc[0]), 16'h0000, "x time");
        check(16'(tcyc[4] - tcyc[3]), 16'h0000, "b time");
        check(16'(tcyc[6] - tcyc[0]), 16'h0012, "inc time");
        check(16'(tcyc[14] - tcyc[0]), 16'h0090, "mul time");
        check({15'h0000, tcyc[15] - tcyc[0] inside {[144:198]}},
              16'h0001, "div time");
        mem_u.store[15'h0010] = 16'h8100;
        mem_u.store[15'h0100] = 16'h0200;
        mem_u.store[15'h0200] = 16'hcafe;
        run(16'h1e10, '{16'h0, 16'h1111, 16'h2222, 16'h7ff0}, 1'b0,
            16'h0000, n);
        check(regs_out.a, 16'hcafe, "ind2");
        check(16'(n - tcyc[0]), 16'h0024, "ind2 time");
        mem_u.store[15'h0011] = 16'h0201;
        mem_u.store[15'h0201] = 16'h0bad;
        run(16'h1e11, '{16'h0, 16'h1111, 16'h2222, 16'h7ff0}, 1'b0,
            16'h0000, n);
        check(regs_out.a, 16'h0bad, "ind1");
        check(16'(n - tcyc[0]), 16'h0012, "ind1 time");
        mem_u.store[15'h0040] = 16'h1357;
        mem_u.store[15'h0041] = 16'h2468;
        run(16'h1040, '{16'h0, 16'h1111, 16'h2222, 16'h7ff0}, 1'b0,
            16'h2041, n);
        check(regs_out.a, 16'h1357, "busy a");
        check(regs_out.b, 16'h1111, "busy b");
        // Slow memory: data only just before the memory cycle ends
        lat = 5'h0f;
        mem_u.store[15'h07ff] = 16'h4321;
        run(16'h17ff, '{16'h0, 16'h1111, 16'h2222, 16'h7ff0}, 1'b0,
            16'h0000, n);
        check(regs_out.a, 16'h4321, "slow");
        lat = 5'h01;
        run(16'h8000, '{16'h0, 16'h1111, 16'h2222, 16'h7ff0}, 1'b0,
            16'h0000, n);
        check({15'h0000, illegal}, 16'h0001, "illegal");
        tally_and_finish();
    end
endmodule
